/* tb/msr_status_regs_props.sv */
`timescale 1ns/1ps
`include "msr_defines.svh"
module msr_chk
(
  input logic ref_clk,
  input logic rst,
  input logic ce,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [`MSR_ADDR_W-1:0] paddr,
  input logic [31:0] prdata,
  input logic pready,
  input logic pslverr,
  input logic irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic st_a;
  assign st_a = paddr == {`MSR_IDX_SPD_STATE, 2'b00} || paddr == {`MSR_IDX_POS_STATE, 2'b00};
  AST_ONE_WAIT: assert property (psel && penable && !pready && ce |=> pready)
    else $error("no answer after one wait state");
  AST_RDY_PULSE: assert property (pready && ce |=> !pready)
    else $error("ready longer than one cycle");
  AST_IDLE_ZERO: assert property ((!pready || pwrite) |-> prdata == 32'h0)
    else $error("read data outside a read answer");
  AST_ERR_PAIR: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error without ready or with data");
  AST_MISALIGN: assert property (pready && paddr[1:0] != 2'b00 |-> pslverr)
    else $error("misaligned access not refused");
  AST_MAPPED: assert property (pready && (paddr == {`MSR_IDX_SPD_SPEED, 2'b00}
    || paddr == {`MSR_IDX_BEMF_D, 2'b00}) |-> !pslverr)
    else $error("mapped word refused");
  AST_STATE_HI: assert property (pready && st_a |-> prdata[31:16] == 16'h0)
    else $error("state word upper half not zero");
  AST_RST_QUIET: assert property ($fell(rst) |-> !irq && !pready)
    else $error("outputs busy right after reset");
  COV_READ: cover property (pready && !pwrite && !pslverr);
  COV_ERR: cover property (pslverr);
  COV_IRQ: cover property ($rose(irq));
endmodule // msr_chk
bind msr_status_regs msr_chk chk (.ref_clk, .rst, .ce, .psel, .penable, .pwrite, .paddr,
  .prdata, .pready, .pslverr, .irq);

/* tb/msr_status_regs_tb.sv */
`timescale 1ns/1ps
`include "msr_defines.svh"
module msr_status_regs_tb
  import msr_pkg::*;
;
  logic ref_clk, rst, ce, psel, penable, pwrite, pready, pslverr, irq, er;
  logic [`MSR_ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [31:0] torque_current_reference, speed_detect_speed, position_detect_angle;
  logic [31:0] backemf_d_estimate;
  logic [15:0] speed_detect_state, position_detect_state;
  logic [5:0] upd;
  logic [3:0] pstrb;
  int num_errors, comparisons;
  logic [11:0] ids [8] = '{`MSR_IDX_TORQUE_REF, `MSR_IDX_SPD_STATE, `MSR_IDX_SPD_SPEED,
    `MSR_IDX_POS_STATE, `MSR_IDX_POS_ANGLE, `MSR_IDX_BEMF_D, `MSR_IDX_EVT_STATUS,
    `MSR_IDX_EVT_MASK};
  logic [31:0] vals [4] = '{32'h8765_4321, 32'hdead_beef, 32'h5a5a_a5a5, 32'hffff_fffe};
  int vi [4] = '{0, 2, 4, 5};

  msr_status_regs uut (.ref_clk, .rst, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .irq, .torque_current_reference,
    .torque_ref_upd(upd[5]), .speed_detect_state, .speed_state_upd(upd[4]),
    .speed_detect_speed, .speed_speed_upd(upd[3]), .position_detect_state,
    .position_state_upd(upd[2]), .position_detect_angle, .position_angle_upd(upd[1]),
    .backemf_d_estimate, .backemf_upd(upd[0]));

  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] idx, input logic [1:0] lo,
    input logic [31:0] wd);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, lo};
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    chk("ready", {31'h0, pready}, 32'h1);
    // Values seen here predate this edge's updates, as the master samples them
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input logic [11:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 2'b00, 32'h0);
    chk("read data", rd, exp);
    chk("error", {31'h0, er}, 32'h0);
  endtask

  task automatic load(input logic [5:0] s);
    @(posedge ref_clk);
    upd <= s;
    @(posedge ref_clk);
    upd <= 6'h0;
  endtask

  task automatic final_report;
    $display("errors %0d, comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    #200us;
    num_errors++;
    final_report;
  end

  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, upd, speed_detect_state} = '0;
    {torque_current_reference, speed_detect_speed, position_detect_angle} = '0;
    {backemf_d_estimate, position_detect_state} = '0;
    rst = 1'b1;
    ce = 1'b1;
    pstrb = 4'hf;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    foreach (ids[i])
      rdc(ids[i], 32'h0);
    torque_current_reference <= vals[0];
    speed_detect_speed <= vals[1];
    position_detect_angle <= vals[2];
    backemf_d_estimate <= vals[3];
    load(6'b101011);
    foreach (vals[i])
    begin
      apb(1'b1, ids[vi[i]], 2'b00, ~vals[i]);
      chk("error", {31'h0, er}, 32'h0);
      rdc(ids[vi[i]], vals[i]);
    end
    for (int s = 0; s <= 4; s++)
    begin
      speed_detect_state <= 16'(s);
      load(6'b010000);
      rdc(`MSR_IDX_SPD_STATE, 32'(s));
    end
    for (int s = 0; s <= 12; s++)
    begin
      position_detect_state <= 16'(s);
      load(6'b000100);
      rdc(`MSR_IDX_POS_STATE, 32'(s));
    end
    // Every done and fault state was entered, but nothing is unmasked yet
    chk("irq", {31'h0, irq}, 32'h0);
    apb(1'b1, `MSR_IDX_EVT_MASK, 2'b00, 32'h5);
    rdc(`MSR_IDX_EVT_MASK, 32'h5);
    chk("irq", {31'h0, irq}, 32'h1);
    rdc(`MSR_IDX_EVT_STATUS, 32'hf);
    rdc(`MSR_IDX_EVT_STATUS, 32'h0);
    chk("irq", {31'h0, irq}, 32'h0);
    speed_detect_state <= MSR_SPD_DONE;
    load(6'b010000);
    repeat (2) @(posedge ref_clk);
    chk("irq", {31'h0, irq}, 32'h1);
    rdc(`MSR_IDX_EVT_STATUS, 32'h1);
    apb(1'b0, 12'h010, 2'b00, 32'h0);
    chk("error", {31'h0, er}, 32'h1);
    chk("read data", rd, 32'h0);
    apb(1'b0, `MSR_IDX_SPD_SPEED, 2'b01, 32'h0);
    chk("error", {31'h0, er}, 32'h1);
    // Mask write with byte lane 0 off and a status write both leave state alone
    pstrb <= 4'he;
    apb(1'b1, `MSR_IDX_EVT_MASK, 2'b00, 32'h0);
    pstrb <= 4'hf;
    rdc(`MSR_IDX_EVT_MASK, 32'h5);
    apb(1'b1, `MSR_IDX_EVT_STATUS, 2'b00, 32'hf);
    chk("error", {31'h0, er}, 32'h0);
    rdc(`MSR_IDX_EVT_STATUS, 32'h0);
    speed_detect_state <= MSR_SPD_FAULT;
    load(6'b010000);
    // Position done lands on the edge that completes the status read; it was not in the snapshot, so it survives
    fork
      rdc(`MSR_IDX_EVT_STATUS, 32'h2);
      begin
        repeat (3) @(posedge ref_clk);
        position_detect_state <= MSR_POS_DONE;
        upd <= 6'b000100;
        @(posedge ref_clk);
        upd <= 6'h0;
      end
    join
    @(posedge ref_clk);
    chk("irq", {31'h0, irq}, 32'h1);
    rdc(`MSR_IDX_EVT_STATUS, 32'h4);
    // A strobe while the clock enable is low must not reach the held word
    ce <= 1'b0;
    torque_current_reference <= 32'h1234_5678;
    load(6'b100000);
    ce <= 1'b1;
    rdc(`MSR_IDX_TORQUE_REF, vals[0]);
    // Reset in mid-run clears loaded words and the mask
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    rdc(`MSR_IDX_SPD_SPEED, 32'h0);
    rdc(`MSR_IDX_BEMF_D, 32'h0);
    rdc(`MSR_IDX_EVT_MASK, 32'h0);
    final_report;
  end
endmodule // msr_status_regs_tb

/* verilog/msr_defines.svh */
`ifndef MSR_DEFINES_SVH
`define MSR_DEFINES_SVH

// APB byte address width; the word index sits in bits 13:2
`define MSR_ADDR_W 14
`define MSR_IDX_W 12
`define MSR_IDX_MSB 13
`define MSR_IDX_LSB 2

// Word indices; the byte address is four times the index
`define MSR_IDX_TORQUE_REF 12'h5fe
`define MSR_IDX_SPD_STATE 12'h67a
`define MSR_IDX_SPD_SPEED 12'h684
`define MSR_IDX_POS_STATE 12'h6b8
`define MSR_IDX_POS_ANGLE 12'h6fc
`define MSR_IDX_BEMF_D 12'h742
`define MSR_IDX_EVT_STATUS 12'h780
`define MSR_IDX_EVT_MASK 12'h781

// Reset values
`define MSR_WORD_RST 32'h0000_0000
`define MSR_EVT_RST 4'h0
`define MSR_STATE_PAD 16'h0000

// State fields live in bits 15:0, bits 31:16 read zero
`define MSR_STATE_MSB 15

// Event status and mask layout
`define MSR_EVT_W 4
`define MSR_EVT_SPD_DONE 0
`define MSR_EVT_SPD_FAULT 1
`define MSR_EVT_POS_DONE 2
`define MSR_EVT_POS_FAULT 3

// Number of algorithm words held
`define MSR_SLOTS 6

`endif

/* verilog/msr_pkg.sv */
package msr_pkg;

  typedef logic [31:0] msr_word_t;

  typedef enum logic [15:0]
  {
    MSR_SPD_INIT = 16'h0000,
    MSR_SPD_STOP_CHECK = 16'h0001,
    MSR_SPD_DIR_CHECK = 16'h0002,
    MSR_SPD_DONE = 16'h0003,
    MSR_SPD_FAULT = 16'h0004
  } msr_spd_state_e;

  typedef enum logic [15:0]
  {
    MSR_POS_INIT = 16'h0000,
    MSR_POS_VECTOR_CONFIG = 16'h0001,
    MSR_POS_RUN = 16'h0002,
    MSR_POS_SLOW_RISE_CLOCK = 16'h0003,
    MSR_POS_SLOW_FALL_CLOCK = 16'h0004,
    MSR_POS_WAIT_DECAY = 16'h0005,
    MSR_POS_GET_TIMES = 16'h0006,
    MSR_POS_SET_NEXT_VECTOR = 16'h0007,
    MSR_POS_CALC_SECTOR_RISE = 16'h0008,
    MSR_POS_CALC_ROTOR_POS = 16'h0009,
    MSR_POS_CALC_ANGLE = 16'h000a,
    MSR_POS_DONE = 16'h000b,
    MSR_POS_FAULT = 16'h000c
  } msr_pos_state_e;

  // Slot numbers of the held words, used to index new_word, load and held_word
  typedef enum logic [2:0]
  {
    MSR_SLOT_TORQUE = 3'b000,
    MSR_SLOT_SPD_STATE = 3'b001,
    MSR_SLOT_SPD_SPEED = 3'b010,
    MSR_SLOT_POS_STATE = 3'b011,
    MSR_SLOT_POS_ANGLE = 3'b100,
    MSR_SLOT_BEMF_D = 3'b101
  } msr_slot_e;

  typedef struct packed
  {
    msr_word_t word;
  } msr_hold_s;

  typedef struct packed
  {
    msr_word_t rdata;
    logic ready;
    logic err;
    logic irq;
    logic [3:0] status;
    logic [3:0] mask;
  } msr_regs_s;

endpackage

/* verilog/msr_status_regs.sv */
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
`include "msr_defines.svh"

// Scaling is done by software: amps = word/2^27*1.25, hertz = word/2^27*max
// speed, degrees = word/2^27*360, volts = word/2^27*60/sqrt(3).
module msr_status_regs
  import msr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`MSR_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic [31:0] torque_current_reference,
  input wire logic torque_ref_upd,
  input wire logic [15:0] speed_detect_state,
  input wire logic speed_state_upd,
  input wire logic [31:0] speed_detect_speed,
  input wire logic speed_speed_upd,
  input wire logic [15:0] position_detect_state,
  input wire logic position_state_upd,
  input wire logic [31:0] position_detect_angle,
  input wire logic position_angle_upd,
  input wire logic [31:0] backemf_d_estimate,
  input wire logic backemf_upd
);

  msr_regs_s r_q;
  msr_regs_s r_d;

  msr_word_t new_word [`MSR_SLOTS];
  msr_word_t held_word [`MSR_SLOTS];
  logic [`MSR_SLOTS-1:0] load;

  logic [`MSR_IDX_W-1:0] idx;
  logic aligned;
  logic access;
  logic complete;
  logic hit;
  msr_word_t read_value;
  logic [`MSR_EVT_W-1:0] events;
  logic [`MSR_EVT_W-1:0] read_clr;
  logic [15:0] spd_old;
  logic [15:0] pos_old;

  // Values from the algorithm, state fields padded so bits 31:16 read zero
  always_comb
  begin
    new_word[MSR_SLOT_TORQUE] = torque_current_reference;
    new_word[MSR_SLOT_SPD_STATE] = {`MSR_STATE_PAD, speed_detect_state};
    new_word[MSR_SLOT_SPD_SPEED] = speed_detect_speed;
    new_word[MSR_SLOT_POS_STATE] = {`MSR_STATE_PAD, position_detect_state};
    new_word[MSR_SLOT_POS_ANGLE] = position_detect_angle;
    new_word[MSR_SLOT_BEMF_D] = backemf_d_estimate;
  end

  always_comb
  begin
    load = '0;
    load[MSR_SLOT_TORQUE] = torque_ref_upd;
    load[MSR_SLOT_SPD_STATE] = speed_state_upd;
    load[MSR_SLOT_SPD_SPEED] = speed_speed_upd;
    load[MSR_SLOT_POS_STATE] = position_state_upd;
    load[MSR_SLOT_POS_ANGLE] = position_angle_upd;
    load[MSR_SLOT_BEMF_D] = backemf_upd;
  end

  // Each word is swapped in one edge; the bus never writes these holders
  genvar g;
  generate
    for (g = 0; g < `MSR_SLOTS; g++)
    begin : g_hold
      msr_word_hold u_hold
      (
        .ref_clk(ref_clk),
        .rst(rst),
        .ce(ce),
        .load(load[g]),
        .din(new_word[g]),
        .dout(held_word[g])
      );
    end
  endgenerate

  // Events fire on entry to a done or fault state, not while it is held
  always_comb
  begin
    spd_old = held_word[MSR_SLOT_SPD_STATE][`MSR_STATE_MSB:0];
    pos_old = held_word[MSR_SLOT_POS_STATE][`MSR_STATE_MSB:0];
    events = '0;
    if (speed_state_upd && (speed_detect_state != spd_old))
    begin
      events[`MSR_EVT_SPD_DONE] = (speed_detect_state == MSR_SPD_DONE);
      events[`MSR_EVT_SPD_FAULT] = (speed_detect_state == MSR_SPD_FAULT);
    end
    if (position_state_upd && (position_detect_state != pos_old))
    begin
      events[`MSR_EVT_POS_DONE] = (position_detect_state == MSR_POS_DONE);
      events[`MSR_EVT_POS_FAULT] = (position_detect_state == MSR_POS_FAULT);
    end
  end

  // Address decode
  always_comb
  begin
    idx = paddr[`MSR_IDX_MSB:`MSR_IDX_LSB];
    aligned = (paddr[1:0] == 2'b00);
    access = psel && penable;
    complete = access && r_q.ready;
  end

  always_comb
  begin
    hit = aligned;
    read_value = `MSR_WORD_RST;
    case (idx)
      `MSR_IDX_TORQUE_REF:
      begin
        read_value = held_word[MSR_SLOT_TORQUE];
      end
      `MSR_IDX_SPD_STATE:
      begin
        read_value = held_word[MSR_SLOT_SPD_STATE];
      end
      `MSR_IDX_SPD_SPEED:
      begin
        read_value = held_word[MSR_SLOT_SPD_SPEED];
      end
      `MSR_IDX_POS_STATE:
      begin
        read_value = held_word[MSR_SLOT_POS_STATE];
      end
      `MSR_IDX_POS_ANGLE:
      begin
        read_value = held_word[MSR_SLOT_POS_ANGLE];
      end
      `MSR_IDX_BEMF_D:
      begin
        read_value = held_word[MSR_SLOT_BEMF_D];
      end
      `MSR_IDX_EVT_STATUS:
      begin
        read_value = {28'h000_0000, r_q.status};
      end
      `MSR_IDX_EVT_MASK:
      begin
        read_value = {28'h000_0000, r_q.mask};
      end
      default:
      begin
        hit = 1'b0;
      end
    endcase
    if (!aligned)
    begin
      read_value = `MSR_WORD_RST;
    end
  end

  // Only the bits that were actually returned are cleared, so an event that
  // lands between the snapshot and the completing edge survives the read
  always_comb
  begin
    read_clr = '0;
    if (complete && !pwrite && hit && (idx == `MSR_IDX_EVT_STATUS))
    begin
      read_clr = r_q.rdata[`MSR_EVT_W-1:0];
    end
  end

  always_comb
  begin
    r_d = r_q;
    // One wait state: the answer is built in the first access cycle
    if (r_q.ready)
    begin
      r_d.ready = 1'b0;
      r_d.err = 1'b0;
      r_d.rdata = `MSR_WORD_RST;
    end
    else if (access)
    begin
      r_d.ready = 1'b1;
      r_d.err = !hit;
      // The whole word is captured on one edge, never assembled in parts
      r_d.rdata = pwrite ? `MSR_WORD_RST : read_value;
    end
    // Writes land only on the mask; value registers drop them silently
    if (complete && pwrite && hit && (idx == `MSR_IDX_EVT_MASK) && pstrb[0])
    begin
      r_d.mask = pwdata[`MSR_EVT_W-1:0];
    end
    // Set beats clear in the same cycle
    r_d.status = (r_q.status & ~read_clr) | events;
    r_d.irq = |(r_d.status & r_d.mask);
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      r_q <= '{rdata: `MSR_WORD_RST, ready: 1'b0, err: 1'b0, irq: 1'b0,
               status: `MSR_EVT_RST, mask: `MSR_EVT_RST};
    end
    else if (ce)
    begin
      r_q <= r_d;
    end
  end

  assign prdata = r_q.rdata;
  assign pready = r_q.ready;
  assign pslverr = r_q.err;
  assign irq = r_q.irq;

endmodule // msr_status_regs

/* verilog/msr_word_hold.sv */
`timescale 1ns/1ps
`include "msr_defines.svh"

// One status word, replaced whole on a load strobe so a read never sees a torn value
module msr_word_hold
  import msr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic load,
  input wire msr_word_t din,
  output msr_word_t dout
);

  msr_hold_s s_q;
  msr_hold_s s_d;

  always_comb
  begin
    s_d = s_q;
    if (load)
    begin
      s_d.word = din;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      s_q <= '{word: `MSR_WORD_RST};
    end
    else if (ce)
    begin
      s_q <= s_d;
    end
  end

  assign dout = s_q.word;

endmodule // msr_word_hold
